/* File: core/rss_consts.vh */
/*
  constants for the reset source sequencer: register offsets, field
  positions, reset values and timing counts.
  assumes a 250 MHz system clock and a word-aligned apb register map.
*/
`ifndef RSS_CONSTS_VH
`define RSS_CONSTS_VH

// register byte offsets
`define RSS_BROWNOUT_CONTROL_OFF 12'h000
`define RSS_RESET_STATUS_OFF     12'h004
`define RSS_STATE_OFF            12'h008

// brownout_control fields
`define RSS_SW_BOR_EN_BIT   7
`define RSS_BOR_READY_BIT   0
`define RSS_SW_BOR_EN_RST   1'b1

// reset_status fields
`define RSS_STK_OVER_BIT    7
`define RSS_STK_UNDER_BIT   6
`define RSS_EXT_RST_N_BIT   3
`define RSS_RI_N_BIT        2
`define RSS_POR_N_BIT       1
`define RSS_BOR_N_BIT       0
`define RSS_TO_N_BIT        4
`define RSS_PD_N_BIT        5

// brownout mode encodings
`define RSS_BOR_MODE_ON     2'b11
`define RSS_BOR_MODE_NSLEEP 2'b10
`define RSS_BOR_MODE_SW     2'b01
`define RSS_BOR_MODE_OFF    2'b00

// timing
`define RSS_CLK_MHZ         250
`define RSS_POWERUP_DELAY_TIMER_MS         64
`define RSS_POWERUP_DELAY_TIMER_CYCLES     (`RSS_POWERUP_DELAY_TIMER_MS * 1000 * `RSS_CLK_MHZ)
`define RSS_BOR_FILT_NS     100
`define RSS_BOR_FILT_CYCLES ((`RSS_BOR_FILT_NS * `RSS_CLK_MHZ + 999) / 1000)
`define RSS_PIN_FILT_NS     200
`define RSS_PIN_FILT_CYCLES ((`RSS_PIN_FILT_NS * `RSS_CLK_MHZ + 999) / 1000)

`endif

/* File: core/rss_reset_source_sequencer.v */
/*
  reset source sequencer: merges every reset source, runs the power-up
  delay timer, filters brown-out and pin dips, and holds the apb-visible
  brown-out control and reset cause flags.
  assumes monitor and pin inputs are asynchronous to clk_in; rst_b_in is
  the raw power-on supervisor output (low while supply too low).
*/
`timescale 1ns/10ps
`include "rss_consts.vh"

module rss_reset_source_sequencer #(
  parameter POWERUP_DELAY_TIMER_CYCLES = `RSS_POWERUP_DELAY_TIMER_CYCLES
) (
  // clock and power-on supervisor reset
  input  wire        clk_in,
  input  wire        rst_b_in,
  // apb slave
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [11:0] paddr_in,
  input  wire [31:0] pwdata_in,
  output reg  [31:0] prdata_out,
  output reg         pready_out,
  output reg         pslverr_out,
  // configuration word bits
  input  wire        powerup_delay_enable_n_in,
  input  wire [1:0]  brownout_mode_cfg_in,
  input  wire        brownout_level_select_in,
  input  wire        ext_reset_pin_enable_in,
  input  wire        low_voltage_prog_enable_in,
  input  wire        stack_reset_enable_in,
  // supply monitor
  input  wire        brownout_below_in,
  input  wire        brownout_circuit_ready_in,
  output reg         brownout_circuit_on_out,
  output reg         brownout_level_select_out,
  // external reset pin
  input  wire        ext_reset_pin_in,
  output reg         ext_reset_pin_out,
  output reg         ext_reset_pin_oe_out,
  output reg         ext_reset_pullup_out,
  output reg         ext_reset_gpio_out,
  input  wire        sw_pullup_in,
  // core events, same clock domain
  input  wire        sleep_in,
  input  wire        wake_req_in,
  input  wire        watchdog_timeout_in,
  input  wire        reset_instr_in,
  input  wire        stack_overflow_in,
  input  wire        stack_underflow_in,
  input  wire        prog_mode_in,
  input  wire        osc_startup_done_in,
  // outputs to the core
  output reg         core_reset_n_out,
  output reg         wake_ok_out
);

  localparam [1:0] ST_POR  = 2'b00;
  localparam [1:0] ST_POWERUP_DELAY_TIMER = 2'b01;
  localparam [1:0] ST_WAIT = 2'b10;
  localparam [1:0] ST_RUN  = 2'b11;
  localparam integer BOR_FILT_I = `RSS_BOR_FILT_CYCLES;
  localparam integer PIN_FILT_I = `RSS_PIN_FILT_CYCLES;
  localparam [7:0] BOR_FILT = BOR_FILT_I[7:0];
  localparam [7:0] PIN_FILT = PIN_FILT_I[7:0];
  localparam [31:0] POWERUP_DELAY_TIMER_LAST = POWERUP_DELAY_TIMER_CYCLES - 1;

  // two-flop synchronisers for async monitor and pin inputs
  reg  [1:0] sync_below;
  reg  [1:0] sync_ready;
  reg  [1:0] sync_pin;
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync_below <= 2'b00;
      sync_ready <= 2'b00;
      sync_pin   <= 2'b11;
    end else begin
      sync_below <= {sync_below[0], brownout_below_in};
      sync_ready <= {sync_ready[0], brownout_circuit_ready_in};
      sync_pin   <= {sync_pin[0], ext_reset_pin_in};
    end
  end
  wire below_s = sync_below[1];
  wire ready_s = sync_ready[1];
  wire pin_s   = sync_pin[1];

  // software enable, register state
  reg        sw_brownout_enable;
  reg        stack_over_flag;
  reg        stack_under_flag;
  reg        reset_instr_flag_n;
  reg        ext_reset_flag_n;
  reg        por_flag_n;
  reg        bor_flag_n;
  reg        timeout_status_n;
  reg        powerdown_status_n;

  // brown-out mode decode; enable bit only counts in software mode
  reg bor_active;
  always @* begin
    case (brownout_mode_cfg_in)
      `RSS_BOR_MODE_ON:     bor_active = 1'b1;
      `RSS_BOR_MODE_NSLEEP: bor_active = !sleep_in;
      `RSS_BOR_MODE_SW:     bor_active = sw_brownout_enable;
      default:              bor_active = 1'b0;
    endcase
  end
  wire mode_waits = brownout_mode_cfg_in[1]; // modes 11 and 10 delay start-up

  // dip filter: only a dip longer than the filter time trips
  reg [7:0] bor_cnt;
  reg       bor_trip;
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bor_cnt  <= 8'h00;
      bor_trip <= 1'b0;
    end else if (bor_active && ready_s && below_s) begin
      if (bor_cnt == BOR_FILT)
        bor_trip <= 1'b1;
      else
        bor_cnt <= bor_cnt + 8'h01;
    end else begin
      bor_cnt  <= 8'h00;
      bor_trip <= 1'b0;
    end
  end

  // pin path: enabled by lvp or enable; low pulses shorter than filter ignored
  wire pin_en = low_voltage_prog_enable_in | ext_reset_pin_enable_in;
  reg [7:0] pin_cnt;
  reg       pin_low;
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_cnt <= 8'h00;
      pin_low <= 1'b0;
    end else if (pin_en && !pin_s) begin
      if (pin_cnt == PIN_FILT)
        pin_low <= 1'b1;
      else
        pin_cnt <= pin_cnt + 8'h01;
    end else begin
      pin_cnt <= 8'h00;
      pin_low <= 1'b0;
    end
  end

  // single-cycle reset events from the core
  wire stk_evt = stack_reset_enable_in & (stack_overflow_in | stack_underflow_in);
  wire evt_rst = watchdog_timeout_in | reset_instr_in | stk_evt;

  // programming-mode exit edge restarts as from power-on
  reg prog_q;
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in)
      prog_q <= 1'b0;
    else
      prog_q <= prog_mode_in;
  end
  wire prog_exit = prog_q & !prog_mode_in;

  // start-up sequencer; power-on hold comes from the async reset itself
  reg [1:0]  state;
  reg [31:0] powerup_delay_timer_cnt;
  reg        hold;
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state    <= ST_POR;
      powerup_delay_timer_cnt <= 32'h00000000;
      hold     <= 1'b1;
    end else if (bor_trip || prog_exit) begin
      state    <= ST_POR;
      powerup_delay_timer_cnt <= 32'h00000000;
      hold     <= 1'b1;
    end else begin
      case (state)
        ST_POR: begin
          // in modes 11 and 10 the timer waits for brown-out release too
          if (!(mode_waits && (!ready_s || below_s))) begin
            powerup_delay_timer_cnt <= 32'h00000000;
            state    <= powerup_delay_enable_n_in ? ST_WAIT : ST_POWERUP_DELAY_TIMER;
          end
        end
        ST_POWERUP_DELAY_TIMER: begin
          if (powerup_delay_timer_cnt == POWERUP_DELAY_TIMER_LAST)
            state <= ST_WAIT;
          else
            powerup_delay_timer_cnt <= powerup_delay_timer_cnt + 32'h00000001;
        end
        ST_WAIT: begin
          // timers run independent of the pin, so a long pin hold ends at once
          if (osc_startup_done_in && !pin_low) begin
            state <= ST_RUN;
            hold  <= 1'b0;
          end
        end
        ST_RUN: begin
          if (pin_low || evt_rst) begin
            state <= ST_WAIT;
            hold  <= 1'b1;
          end
        end
        default: state <= ST_POR;
      endcase
    end
  end

  // output reset: rst_any asserts at the next edge, rst_b_in at once; release through two flops
  wire       rst_any = hold | bor_trip | pin_low | evt_rst;
  reg  [1:0] rel_sync;
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in)
      rel_sync <= 2'b00;
    else if (rst_any)
      rel_sync <= 2'b00;
    else
      rel_sync <= {rel_sync[0], 1'b1};
  end

  // cause flags; hardware set wins over software write in the same cycle
  wire wr  = psel_in & penable_in & pwrite_in & pready_out;
  wire rd  = psel_in & !penable_in & !pwrite_in;
  wire wbc = wr & (paddr_in == `RSS_BROWNOUT_CONTROL_OFF);
  wire wrs = wr & (paddr_in == `RSS_RESET_STATUS_OFF);
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sw_brownout_enable <= `RSS_SW_BOR_EN_RST;
      stack_over_flag    <= 1'b0;
      stack_under_flag   <= 1'b0;
      reset_instr_flag_n <= 1'b1;
      ext_reset_flag_n   <= 1'b1;
      por_flag_n         <= 1'b0;
      bor_flag_n         <= 1'b1;
      timeout_status_n   <= 1'b1;
      powerdown_status_n <= 1'b1;
    end else begin
      if (wbc)
        sw_brownout_enable <= pwdata_in[`RSS_SW_BOR_EN_BIT];
      if (wrs) begin
        stack_over_flag    <= pwdata_in[`RSS_STK_OVER_BIT];
        stack_under_flag   <= pwdata_in[`RSS_STK_UNDER_BIT];
        reset_instr_flag_n <= pwdata_in[`RSS_RI_N_BIT];
        ext_reset_flag_n   <= pwdata_in[`RSS_EXT_RST_N_BIT];
        por_flag_n         <= pwdata_in[`RSS_POR_N_BIT];
        bor_flag_n         <= pwdata_in[`RSS_BOR_N_BIT];
      end
      if (stack_reset_enable_in && stack_overflow_in)
        stack_over_flag <= 1'b1;
      if (stack_reset_enable_in && stack_underflow_in)
        stack_under_flag <= 1'b1;
      if (reset_instr_in)
        reset_instr_flag_n <= 1'b0;
      if (pin_low)
        ext_reset_flag_n <= 1'b0;
      if (bor_trip)
        bor_flag_n <= 1'b0;
      if (prog_exit)
        por_flag_n <= 1'b0;
      if (watchdog_timeout_in) begin
        timeout_status_n   <= 1'b0;
        powerdown_status_n <= !sleep_in;
      end else if (sleep_in) begin
        powerdown_status_n <= 1'b0;
      end
    end
  end

  // apb slave: zero wait state, unmapped reads zero with slverr
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prdata_out  <= 32'h00000000;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= psel_in & !penable_in;
      pslverr_out <= psel_in & !penable_in &
                     (paddr_in != `RSS_BROWNOUT_CONTROL_OFF) &
                     (paddr_in != `RSS_RESET_STATUS_OFF) &
                     (paddr_in != `RSS_STATE_OFF);
      prdata_out  <= 32'h00000000;
      if (rd) begin
        case (paddr_in)
          `RSS_BROWNOUT_CONTROL_OFF:
            prdata_out <= {24'h000000, sw_brownout_enable, 6'h00, ready_s};
          `RSS_RESET_STATUS_OFF:
            prdata_out <= {24'h000000, stack_over_flag, stack_under_flag,
                           powerdown_status_n, timeout_status_n, ext_reset_flag_n,
                           reset_instr_flag_n, por_flag_n, bor_flag_n};
          `RSS_STATE_OFF:
            prdata_out <= {28'h0000000, state, hold, bor_active};
          default: prdata_out <= 32'h00000000;
        endcase
      end
    end
  end

  // core, pin and monitor outputs, all registered
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      core_reset_n_out          <= 1'b0;
      wake_ok_out               <= 1'b0;
      brownout_circuit_on_out   <= 1'b0;
      brownout_level_select_out <= 1'b0;
      ext_reset_pin_out         <= 1'b0;
      ext_reset_pin_oe_out      <= 1'b0;
      ext_reset_pullup_out      <= 1'b1;
      ext_reset_gpio_out        <= 1'b1;
    end else begin
      core_reset_n_out          <= rel_sync[1] & !rst_any;
      // off-in-sleep mode waits for ready on wake; always-on does not
      wake_ok_out               <= wake_req_in &
                                   ((brownout_mode_cfg_in != `RSS_BOR_MODE_NSLEEP) | ready_s);
      brownout_circuit_on_out   <= bor_active;
      brownout_level_select_out <= brownout_level_select_in;
      ext_reset_pin_out         <= 1'b0;
      ext_reset_pin_oe_out      <= 1'b0;
      ext_reset_pullup_out      <= pin_en | sw_pullup_in;
      ext_reset_gpio_out        <= pin_en ? 1'b1 : pin_s;
    end
  end

endmodule

/* File: bench/rss_checker_assertions.sv */
/* port checker for the reset source sequencer.
   assumes it is bound into the top module by port name. */
`timescale 1ns/10ps
module rss_checker (
  // clock, reset and events
  input wire clk_in,
  input wire rst_b_in,
  input wire reset_instr_in,
  input wire watchdog_timeout_in,
  input wire stack_overflow_in,
  input wire stack_underflow_in,
  input wire stack_reset_enable_in,
  input wire osc_startup_done_in,
  // reset pin, its configuration and the core reset
  input wire ext_reset_pin_in,
  input wire ext_reset_pin_enable_in,
  input wire low_voltage_prog_enable_in,
  input wire sw_pullup_in,
  input wire ext_reset_pin_out,
  input wire ext_reset_pin_oe_out,
  input wire ext_reset_pullup_out,
  input wire core_reset_n_out
);
  reg  [5:0] pin_low_cnt;
  wire       pin_on = ext_reset_pin_enable_in | low_voltage_prog_enable_in;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  // length of the present press; saturates so a long hold stays visible
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in)
      pin_low_cnt <= 6'h00;
    else if (!pin_on || ext_reset_pin_in)
      pin_low_cnt <= 6'h00;
    else if (pin_low_cnt != 6'h3F)
      pin_low_cnt <= pin_low_cnt + 6'h01;
  end

  property p_pin_undriven;
    !ext_reset_pin_oe_out && !ext_reset_pin_out;
  endproperty
  a_pin_undriven: assert property (p_pin_undriven)
    else $error("reset pin driven");
  property p_instr_reset;
    reset_instr_in |=> !core_reset_n_out;
  endproperty
  a_instr_reset: assert property (p_instr_reset)
    else $error("no reset after reset instruction");
  property p_wdt_reset;
    watchdog_timeout_in |=> !core_reset_n_out;
  endproperty
  a_wdt_reset: assert property (p_wdt_reset)
    else $error("no reset after watchdog timeout");
  property p_stack_reset;
    stack_reset_enable_in && (stack_overflow_in || stack_underflow_in) |=> !core_reset_n_out;
  endproperty
  a_stack_reset: assert property (p_stack_reset)
    else $error("no reset after stack error");
  property p_pin_hold;
    pin_low_cnt >= 6'h3C |-> !core_reset_n_out;
  endproperty
  a_pin_hold: assert property (p_pin_hold)
    else $error("core runs while pin held low");
  property p_release_osc;
    $rose(core_reset_n_out) |-> $past(osc_startup_done_in);
  endproperty
  a_release_osc: assert property (p_release_osc)
    else $error("core released before oscillator ready");
  property p_release_sync;
    $rose(core_reset_n_out) |-> $past(rst_b_in, 2);
  endproperty
  a_release_sync: assert property (p_release_sync)
    else $error("core released without synchroniser delay");
  property p_pin_pullup;
    pin_on [*2] |-> ext_reset_pullup_out;
  endproperty
  a_pin_pullup: assert property (p_pin_pullup)
    else $error("pull-up off on reset pin");
  property p_gpio_pullup;
    !pin_on [*2] ##0 $stable(sw_pullup_in) |-> ext_reset_pullup_out == sw_pullup_in;
  endproperty
  a_gpio_pullup: assert property (p_gpio_pullup)
    else $error("pull-up not under software control");
endmodule

bind rss_reset_source_sequencer rss_checker i_chk (.*);

/* File: bench/rss_far_side.sv */
/* far side: supply monitor, reset pin with pull-up, watchdog.
   assumes the bench steers dips, presses and watchdog clears. */
`timescale 1ns/10ps
module rss_far_side #(
  parameter WDT_LIMIT = 40
) (
  // requests from the bench
  input  wire clk_in,
  input  wire dip_in,
  input  wire press_in,
  input  wire kick_in,
  // lines towards the block
  output reg  below_out = 1'h1,
  output reg  ready_out = 1'h0,
  output wire pin_out,
  output reg  wdt_out = 1'h0
);
  reg [2:0] rdy_cnt = 3'h0;
  reg [7:0] wdt_cnt = 8'h00;

  // released pin floats up to the pull-up, never keeps a low
  assign pin_out = !press_in;

  // monitor level, late readiness, and a watchdog that bites unless cleared
  always @(posedge clk_in) begin
    below_out <= dip_in;
    if (rdy_cnt != 3'h7)
      rdy_cnt <= rdy_cnt + 3'h1;
    ready_out <= (rdy_cnt == 3'h7);
    wdt_out <= !kick_in && (wdt_cnt == WDT_LIMIT);
    wdt_cnt <= (kick_in || wdt_cnt == WDT_LIMIT) ? 8'h00 : wdt_cnt + 8'h01;
  end
endmodule

/* File: bench/rss_reset_source_sequencer_bench.sv */
/* bench for the reset source sequencer: apb master, events, presses, dips.
   assumes the far-side model and the bound checker. */
`timescale 1ns/10ps
module rss_reset_source_sequencer_bench;
  // inputs, all set at time zero
  logic        clk_in = 1'h0, rst_b_in = 1'h0, psel_in = 1'h0, penable_in = 1'h0;
  logic        pwrite_in = 1'h0, powerup_delay_enable_n_in = 1'h0, sleep_in = 1'h0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0, q;
  logic [1:0]  brownout_mode_cfg_in = 2'h3;
  logic        brownout_level_select_in = 1'h0, ext_reset_pin_enable_in = 1'h1;
  logic        low_voltage_prog_enable_in = 1'h0, stack_reset_enable_in = 1'h1;
  logic        sw_pullup_in = 1'h0, wake_req_in = 1'h0, reset_instr_in = 1'h0;
  logic        stack_overflow_in = 1'h0, stack_underflow_in = 1'h0, prog_mode_in = 1'h0;
  logic        osc_startup_done_in = 1'h1, dip = 1'h1, press = 1'h0, kick = 1'h1, e, f;
  // outputs and far-side lines
  wire [31:0]  prdata_out;
  wire         pready_out, pslverr_out, brownout_circuit_on_out, brownout_level_select_out;
  wire         ext_reset_pin_out, ext_reset_pin_oe_out, ext_reset_pullup_out;
  wire         ext_reset_gpio_out, core_reset_n_out, wake_ok_out, far_pin;
  wire         ext_reset_pin_in, brownout_below_in, brownout_circuit_ready_in;
  wire         watchdog_timeout_in;
  integer      seed = 32'hB9FEA0B4, r;
  int          n_errors = 0, total_checks = 0, i, j;
  int          flag_pos [4] = '{2, 4, 7, 1};
  bit [3:0]    dips [7] = '{4'hD, 4'hB, 4'h7, 4'h6, 4'h4, 4'hA, 4'h3};

  rss_reset_source_sequencer #(.POWERUP_DELAY_TIMER_CYCLES(20)) i_dut (.*);
  rss_far_side i_far (.clk_in, .dip_in(dip), .press_in(press), .kick_in(kick),
    .below_out(brownout_below_in), .ready_out(brownout_circuit_ready_in),
    .pin_out(far_pin), .wdt_out(watchdog_timeout_in));
  // wire level of the open-drain pin
  assign ext_reset_pin_in = ext_reset_pin_oe_out ? ext_reset_pin_out : far_pin;

  initial forever #2 clk_in = ~clk_in;

  task automatic chk(input [31:0] got, input [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("errors %0d checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic fail_out;
    n_errors++;
    complete_run();
  endtask
  // one apb transfer; waits for pready at most 20 edges
  task automatic apb(input w, input [11:0] a, input [31:0] d);
    int k;
    @(posedge clk_in);
    psel_in <= 1'h1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'h1;
    k = 0;
    do begin
      @(posedge clk_in);
      k++;
    end while (pready_out !== 1'h1 && k < 20);
    if (k >= 20)
      fail_out();
    q = prdata_out;
    e = pslverr_out;
    psel_in <= 1'h0;
    penable_in <= 1'h0;
  endtask
  // did the core reset at any edge within n cycles
  task automatic watch(input int n);
    f = 1'h0;
    repeat (n) begin
      @(posedge clk_in);
      if (core_reset_n_out === 1'h0)
        f = 1'h1;
    end
  endtask
  task automatic wait_run;
    for (i = 0; i < 400 && core_reset_n_out !== 1'h1; i++)
      @(posedge clk_in);
    if (i == 400)
      fail_out();
  endtask
  // brown-out trips: forced on in 11, off asleep in 10, enable bit in 01
  function automatic bit bor_trips(input [3:0] c);
    return c[3:2] == 2'h3 || (c[3:2] == 2'h2 && !c[0]) || (c[3:2] == 2'h1 && c[1]);
  endfunction

  initial begin
    repeat (3) @(posedge clk_in);
    chk(core_reset_n_out, 1'h0);
    rst_b_in <= 1'h1;
    repeat (30) @(posedge clk_in);
    chk(core_reset_n_out, 1'h0);
    dip <= 1'h0;
    wait_run();
    chk(i >= 20, 1'h1);
    apb(1'h0, 12'h000, 32'h0);
    chk(q, 32'h81);
    r = $random(seed);
    apb(1'h1, 12'h000, r & 32'h7F);
    apb(1'h0, 12'h000, 32'h0);
    chk(q, 32'h01);
    apb(1'h0, 12'h00C, 32'h0);
    chk(e, 1'h1);
    chk(q, 32'h0);
    brownout_level_select_in <= r[8];
    watch(3);
    chk(brownout_level_select_out, r[8]);
    // set the writable active-low cause flags and clear the stack flags so that each event must change its own
    apb(1'h1, 12'h004, 32'h0F);
    apb(1'h0, 12'h004, 32'h0);
    chk(q, 32'h3F);
    // reset events, then the cause flag each leaves
    for (j = 0; j < 4; j++) begin
      @(posedge clk_in);
      reset_instr_in <= (j == 0);
      kick <= (j != 1);
      stack_overflow_in <= (j == 2);
      prog_mode_in <= (j == 3);
      @(posedge clk_in);
      reset_instr_in <= 1'h0;
      stack_overflow_in <= 1'h0;
      prog_mode_in <= 1'h0;
      watch(60);
      chk(f, 1'h1);
      kick <= 1'h1;
      wait_run();
      apb(1'h0, 12'h004, 32'h0);
      chk(q[flag_pos[j]], j == 2);
    end
    stack_reset_enable_in <= 1'h0;
    stack_underflow_in <= 1'h1;
    @(posedge clk_in);
    stack_underflow_in <= 1'h0;
    watch(10);
    chk(f, 1'h0);
    // slow oscillator keeps the core in reset after an event
    osc_startup_done_in <= 1'h0;
    @(posedge clk_in);
    reset_instr_in <= 1'h1;
    @(posedge clk_in);
    reset_instr_in <= 1'h0;
    watch(60);
    chk(core_reset_n_out, 1'h0);
    osc_startup_done_in <= 1'h1;
    wait_run();
    r = $random(seed);
    press <= 1'h1;
    repeat (1 + r[3:0]) @(posedge clk_in);
    press <= 1'h0;
    watch(60);
    chk(f, 1'h0);
    // long press with the pin enabled, with lvp only, and with neither
    for (j = 0; j < 3; j++) begin
      r = $random(seed);
      {ext_reset_pin_enable_in, low_voltage_prog_enable_in} <= 2'h2 - j;
      sw_pullup_in <= r[0];
      press <= 1'h1;
      watch(80);
      chk(f, j < 2);
      chk(ext_reset_gpio_out, j < 2);
      chk(ext_reset_pullup_out, j < 2 || r[0]);
      press <= 1'h0;
      wait_run();
    end
    r = $random(seed);
    dip <= 1'h1;
    repeat (1 + r[3:0]) @(posedge clk_in);
    dip <= 1'h0;
    watch(40);
    chk(f, 1'h0);
    // long dips by mode, enable bit and sleep
    foreach (dips[k]) begin
      apb(1'h1, 12'h000, {24'h0, dips[k][1], 7'h00});
      brownout_mode_cfg_in <= dips[k][3:2];
      sleep_in <= dips[k][0];
      dip <= 1'h1;
      watch(40);
      chk(f, bor_trips(dips[k]));
      dip <= 1'h0;
      sleep_in <= 1'h0;
      wait_run();
    end
    // timer disabled: restart after a brown-out skips the delay
    powerup_delay_enable_n_in <= 1'h1;
    brownout_mode_cfg_in <= 2'h3;
    dip <= 1'h1;
    watch(40);
    chk(f, 1'h1);
    dip <= 1'h0;
    wait_run();
    chk(i < 20, 1'h1);
    complete_run();
  end
endmodule
